// [logic/sgp_ports.sv]
// Purpose: first (8-bit, converter shared) and second (5-bit) gpio ports
// Assumes: strobes one cycle, read data valid the cycle after the read strobe
// Notes: data latches have no reset, as ports keep their values
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.svh"
module sgp_ports #(
  parameter int FIRST_W = 8,
  parameter int SECOND_W = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [4:0] converter_channel_select,
  input wire logic bus_clock,
  input wire logic [FIRST_W-1:0] first_pin_in,
  output logic [FIRST_W-1:0] first_pin_out,
  output logic [FIRST_W-1:0] first_pin_oe,
  input wire logic [SECOND_W-1:0] second_pin_in,
  output logic [SECOND_W-1:0] second_pin_out,
  output logic [SECOND_W-1:0] second_pin_oe
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic sgp_pkg::sgp_sel_t sgp_decode(input logic [7:0] a);
    case (a)
      `SGP_ADDR_FIRST_LATCH: sgp_decode = sgp_pkg::SGP_SEL_FIRST_LATCH;
      `SGP_ADDR_SECOND_LATCH: sgp_decode = sgp_pkg::SGP_SEL_SECOND_LATCH;
      `SGP_ADDR_FIRST_DIR: sgp_decode = sgp_pkg::SGP_SEL_FIRST_DIR;
      `SGP_ADDR_SECOND_DIR: sgp_decode = sgp_pkg::SGP_SEL_SECOND_DIR;
      default: sgp_decode = sgp_pkg::SGP_SEL_NONE;
    endcase
  endfunction

  sgp_pkg::sgp_sel_t sel;
  logic [FIRST_W-1:0] first_port_latch_reg;
  logic [FIRST_W-1:0] first_port_direction_reg;
  logic [SECOND_W-1:0] second_port_latch_reg;
  logic [SECOND_W-1:0] second_port_direction_reg;
  logic bus_clock_out_enable_reg;
  logic [FIRST_W-1:0] first_read;
  logic [FIRST_W-1:0] analog_use;
  logic [SECOND_W-1:0] second_read;
  logic [SECOND_W-1:0] second_oe_raw;
  logic [7:0] rdata_next;

  assign sel = sgp_decode(reg_addr);

  // ---------------------------------------------------------------
  // data latches, no reset
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    // writes land regardless of direction; reset leaves them
    if (reg_wr && sel == sgp_pkg::SGP_SEL_FIRST_LATCH) begin
      first_port_latch_reg <= reg_wdata[FIRST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reg_wr && sel == sgp_pkg::SGP_SEL_SECOND_LATCH) begin
      second_port_latch_reg <= reg_wdata[SECOND_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      first_port_direction_reg <= FIRST_W'(`SGP_DIR_RESET);
    end else if (reg_wr && sel == sgp_pkg::SGP_SEL_FIRST_DIR) begin
      first_port_direction_reg <= reg_wdata[FIRST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      second_port_direction_reg <= SECOND_W'(`SGP_DIR_RESET);
      bus_clock_out_enable_reg <= 1'b0;
    end else if (reg_wr && sel == sgp_pkg::SGP_SEL_SECOND_DIR) begin
      second_port_direction_reg <= reg_wdata[SECOND_W-1:0];
      bus_clock_out_enable_reg <= reg_wdata[`SGP_CLK_OUT_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // pin slices
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FIRST_W; gi++) begin : g_first
      // channel select equal to pin index claims it for the converter
      assign analog_use[gi] = (converter_channel_select == 5'(gi));
      sgp_port_bit u_bit (
        .latch_bit(first_port_latch_reg[gi]),
        .dir_bit(first_port_direction_reg[gi]),
        .pin_in(first_pin_in[gi]),
        .analog_use(analog_use[gi]),
        .read_bit(first_read[gi]),
        .drive_en(first_pin_oe[gi])
      );
    end
    for (gi = 0; gi < SECOND_W; gi++) begin : g_second
      sgp_port_bit u_bit (
        .latch_bit(second_port_latch_reg[gi]),
        .dir_bit(second_port_direction_reg[gi]),
        .pin_in(second_pin_in[gi]),
        .analog_use(1'b0),
        .read_bit(second_read[gi]),
        .drive_en(second_oe_raw[gi])
      );
    end
  endgenerate

  assign first_pin_out = first_port_latch_reg;

  // pin2 carries the bus clock when enabled; combinational so it is not divided
  always_comb begin
    second_pin_out = second_port_latch_reg;
    second_pin_oe = second_oe_raw;
    if (bus_clock_out_enable_reg) begin
      second_pin_out[`SGP_CLK_PIN] = bus_clock;
      second_pin_oe[`SGP_CLK_PIN] = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read path, unmapped reads return zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    case (sel)
      sgp_pkg::SGP_SEL_FIRST_LATCH: rdata_next[FIRST_W-1:0] = first_read;
      sgp_pkg::SGP_SEL_SECOND_LATCH: rdata_next[SECOND_W-1:0] = second_read;
      sgp_pkg::SGP_SEL_FIRST_DIR: rdata_next[FIRST_W-1:0] = first_port_direction_reg;
      sgp_pkg::SGP_SEL_SECOND_DIR: begin
        rdata_next[SECOND_W-1:0] = second_port_direction_reg;
        rdata_next[`SGP_CLK_OUT_EN_BIT] = bus_clock_out_enable_reg;
      end
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [logic/sgp_map.svh]
// Purpose: register map, field positions and reset values of the shared port block
// Assumes: byte-wide register port, one register per address
// Notes: direction register addresses are chosen locally
//
// Contract
// - channel select picks converter pin or gpio
// - converter pin, direction in: read zero
// - converter pin, direction out: read latch
// - converter pin stays input whatever direction
// - first direction one enables driver
// - reset clears first direction register
// - first read: latch if output, else pin
// - data writes always update latch
// - second port: five pins, latch and direction
// - reset keeps second port latches
// - enable bit drives bus clock onto pin2
// - enable bit readable, writable, reset clear
// - second direction one enables driver
// - reset clears second direction register
// - second read: latch if output, else pin
// - reset keeps first port latches
`ifndef SGP_MAP_SVH
`define SGP_MAP_SVH

// ---------------------------------------------------------------
// addresses
// ---------------------------------------------------------------
`define SGP_ADDR_FIRST_LATCH 8'h01
`define SGP_ADDR_SECOND_LATCH 8'h02
`define SGP_ADDR_FIRST_DIR 8'h05
`define SGP_ADDR_SECOND_DIR 8'h06

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define SGP_CLK_OUT_EN_BIT 7
`define SGP_CLK_PIN 2
`define SGP_DIR_RESET 8'h00
`define SGP_CH_NONE 5'h1f

`endif

// [logic/sgp_pkg.sv]
// Purpose: shared types of the shared port block
// Assumes: nothing
// Notes: register selection decoded once
`default_nettype none
package sgp_pkg;
  typedef enum logic [4:0] {
    SGP_SEL_NONE = 5'b00001,
    SGP_SEL_FIRST_LATCH = 5'b00010,
    SGP_SEL_SECOND_LATCH = 5'b00100,
    SGP_SEL_FIRST_DIR = 5'b01000,
    SGP_SEL_SECOND_DIR = 5'b10000
  } sgp_sel_t;
endpackage
`default_nettype wire

// [logic/sgp_port_bit.sv]
// Purpose: one pin of a port, read mux and driver control
// Assumes: pin input already synchronous to clk_sys
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module sgp_port_bit (
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic pin_in,
  input wire logic analog_use,
  output logic read_bit,
  output logic drive_en
);
  // ---------------------------------------------------------------
  // read and drive
  // ---------------------------------------------------------------
  always_comb begin
    if (dir_bit) begin
      read_bit = latch_bit;
    end else if (analog_use) begin
      read_bit = 1'b0;
    end else begin
      read_bit = pin_in;
    end
  end
  // converter owns the pin, driver stays off
  assign drive_en = dir_bit & ~analog_use;
endmodule
`default_nettype wire

// [dv/sgp_ports_asserts.sv]
// Purpose: port-level checks of the shared port block
// Assumes: one clock, sync reset
// Notes: pin2 output data is left out of latch checks, clock-out overrides it
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.svh"
module sgp_ports_asserts #(
  parameter int FIRST_W = 8,
  parameter int SECOND_W = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [4:0] converter_channel_select,
  input wire logic bus_clock,
  input wire logic [FIRST_W-1:0] first_pin_in,
  input wire logic [FIRST_W-1:0] first_pin_out,
  input wire logic [FIRST_W-1:0] first_pin_oe,
  input wire logic [SECOND_W-1:0] second_pin_in,
  input wire logic [SECOND_W-1:0] second_pin_out,
  input wire logic [SECOND_W-1:0] second_pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_reset_dirs: assert property (
    $fell(sys_rst) |-> first_pin_oe == 8'h00 && second_pin_oe == 5'h00) else $error("oe after reset");
  chk_conv_hiz: assert property (
    converter_channel_select < 5'h08 |-> !first_pin_oe[converter_channel_select[2:0]])
    else $error("converter pin driven");
  // claimed pin masked in the consequent, so a select change on the write edge is allowed
  chk_first_dir: assert property (
    reg_wr && reg_addr == `SGP_ADDR_FIRST_DIR
    |=> first_pin_oe == ($past(reg_wdata) & ~((converter_channel_select < 5'h08)
    ? (8'h01 << converter_channel_select[2:0]) : 8'h00))) else $error("first oe wrong");
  chk_second_dir: assert property (
    reg_wr && reg_addr == `SGP_ADDR_SECOND_DIR && !reg_wdata[7]
    |=> second_pin_oe == $past(reg_wdata[4:0])) else $error("second oe wrong");
  chk_clk_out: assert property (
    reg_wr && reg_addr == `SGP_ADDR_SECOND_DIR && reg_wdata[7]
    |=> second_pin_oe[2] && second_pin_out[2] == bus_clock) else $error("clock out wrong");
  chk_first_latch: assert property (
    reg_wr && reg_addr == `SGP_ADDR_FIRST_LATCH |=> first_pin_out == $past(reg_wdata))
    else $error("first latch wrong");
  chk_second_latch: assert property (
    reg_wr && reg_addr == `SGP_ADDR_SECOND_LATCH |=> second_pin_out[4:3] == $past(reg_wdata[4:3])
    && second_pin_out[1:0] == $past(reg_wdata[1:0])) else $error("second latch wrong");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside slot");
endmodule
bind sgp_ports sgp_ports_asserts #(.FIRST_W(FIRST_W), .SECOND_W(SECOND_W)) sgp_ports_asserts_inst (.*);
`default_nettype wire

// [dv/sgp_pins_model.sv]
// Purpose: pad model, driver wins over the outside level
// Assumes: no contention modelled
// Notes: undriven pins show the bench's outside pattern
`timescale 1ns/1ps
`default_nettype none
module sgp_pins_model (
  input wire logic [7:0] f_out,
  input wire logic [7:0] f_oe,
  input wire logic [7:0] f_ext,
  output logic [7:0] f_in,
  input wire logic [4:0] s_out,
  input wire logic [4:0] s_oe,
  input wire logic [4:0] s_ext,
  output logic [4:0] s_in
);
  assign f_in = (f_oe & f_out) | (~f_oe & f_ext);
  assign s_in = (s_oe & s_out) | (~s_oe & s_ext);
endmodule
`default_nettype wire

// [dv/sgp_ports_tb.sv]
// Purpose: self-checking bench of the shared port block
// Assumes: pad model resolves pins
// Notes: latches are written before direction, avoiding pin glitches
`timescale 1ns/1ps
`default_nettype none
`include "sgp_map.svh"
module sgp_ports_tb;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bus_clock = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, fo, foe, fi, fx = 8'h3c;
  logic [4:0] sel = 5'h1f, so, soe, si, sx = 5'h0a;
  int failures = 0, samples_checked = 0;
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) bus_clock <= ~bus_clock;
  sgp_ports sgp_ports_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .converter_channel_select(sel), .bus_clock(bus_clock), .first_pin_in(fi),
    .first_pin_out(fo), .first_pin_oe(foe), .second_pin_in(si), .second_pin_out(so),
    .second_pin_oe(soe));
  sgp_pins_model sgp_pins_model_inst (.f_out(fo), .f_oe(foe), .f_ext(fx), .f_in(fi),
    .s_out(so), .s_oe(soe), .s_ext(sx), .s_in(si));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic do_reset;
    // assert on an edge so a mid-run reset never lands between edges
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask
  task automatic s_first;
    rd(`SGP_ADDR_FIRST_DIR, 8'h00);
    rd(`SGP_ADDR_SECOND_DIR, 8'h00);
    wr(`SGP_ADDR_FIRST_LATCH, 8'ha5);
    rd(`SGP_ADDR_FIRST_LATCH, 8'h3c);
    wr(`SGP_ADDR_FIRST_DIR, 8'hf0);
    rd(`SGP_ADDR_FIRST_LATCH, 8'hac);
    chk(foe, 8'hf0);
    wr(8'h09, 8'hff);
    rd(8'h09, 8'h00);
  endtask
  task automatic s_conv;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      sel <= i[4:0];
      rd(`SGP_ADDR_FIRST_LATCH, 8'ha0 | (8'h0c & ~(8'h01 << i)));
      chk(foe, 8'hf0 & ~(8'h01 << i));
    end
    @(posedge clk_sys);
    sel <= 5'h1f;
  endtask
  task automatic s_second;
    wr(`SGP_ADDR_SECOND_LATCH, 8'h15);
    wr(`SGP_ADDR_SECOND_DIR, 8'h03);
    rd(`SGP_ADDR_SECOND_LATCH, 8'h09);
    wr(`SGP_ADDR_SECOND_DIR, 8'h83);
    rd(`SGP_ADDR_SECOND_DIR, 8'h83);
    repeat (2) begin
      @(posedge clk_sys);
      #1 chk({3'h0, soe}, 8'h07);
      chk({7'h00, so[2]}, {7'h00, bus_clock});
    end
  endtask
  task automatic s_keep;
    do_reset();
    chk({3'h0, soe}, 8'h00);
    chk(foe, 8'h00);
    rd(`SGP_ADDR_FIRST_DIR, 8'h00);
    rd(`SGP_ADDR_SECOND_DIR, 8'h00);
    wr(`SGP_ADDR_FIRST_DIR, 8'hff);
    wr(`SGP_ADDR_SECOND_DIR, 8'h1f);
    rd(`SGP_ADDR_FIRST_LATCH, 8'ha5);
    rd(`SGP_ADDR_SECOND_LATCH, 8'h15);
  endtask
  task automatic stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    do_reset();
    s_first();
    s_conv();
    s_second();
    s_keep();
    stop_test();
  end
  initial begin
    #20000;
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
